/* core/gst_map.vh */
`ifndef GST_MAP_VH
`define GST_MAP_VH
// ============================================================
// timing figures, in their own units
`define GST_CLK_HZ          20000000
`define GST_CYCLE_S         1
`define GST_BUSOFF_S        2
`define GST_CAL_S           5
`define GST_RECOVER_US      1000
`define GST_TIMEOUT_MIN_US  25
`define GST_TIMEOUT_MAX_US  35
// ============================================================
// derived cycle counts
`define GST_CYCLE_CYC       (`GST_CYCLE_S * `GST_CLK_HZ)
`define GST_BUSOFF_CYC      (`GST_BUSOFF_S * `GST_CLK_HZ)
`define GST_CAL_CYC         (`GST_CAL_S * `GST_CLK_HZ)
`define GST_RECOVER_CYC     ((`GST_RECOVER_US * (`GST_CLK_HZ / 1000000)))
`define GST_TIMEOUT_CYC     ((`GST_TIMEOUT_MAX_US * (`GST_CLK_HZ / 1000000)))
// ============================================================
// mode encodings
`define GST_MODE_NORMAL     2'h0
`define GST_MODE_SLEEP      2'h1
`define GST_MODE_SHUTDOWN   2'h2
// temperature source select
`define GST_TSRC_INTERNAL   2'h0
`define GST_TSRC_EXT_A      2'h1
`define GST_TSRC_EXT_B      2'h2
`define GST_TSRC_EXT_MAX    2'h3
// widths
`define GST_TIMER_W         32
`endif

/* core/gst_sync.v */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// three-stage synchroniser; a change is taken once stages two and three agree
module gst_sync #(
	parameter RESET_VAL = 1'b0
) (
	// clock and reset
	input  wire clk,
	input  wire rst,
	// asynchronous level in, filtered level out
	input  wire din,
	output reg  dout
);
	reg s1; // metastability catcher, read only by s2
	reg s2;
	reg s3;

	// ============================================================
	// shift chain and agreement filter
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s1   <= RESET_VAL;
			s2   <= RESET_VAL;
			s3   <= RESET_VAL;
			dout <= RESET_VAL;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			// only update when the two settled stages agree
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule
`default_nettype wire

/* core/gst_supervisor.v */
`timescale 1ns/1ps
`default_nettype none
`include "gst_map.vh"

// How it works
// - normal mode runs one cycle per second
// - sleep mode cycles at configurable interval
// - current or fault wakes from sleep
// - shutdown disables every function but PEC enable and bus-off clear
// - system present sampled once per cycle
// - low present input means system present
// - positive sense charge, negative discharge
// - signed sense accumulated in counter
// - cell voltage refreshed every cycle
// - both lines low 5 s starts calibration
// - both lines low 2 s enters bus-off
// - either line high clears bus-off
// - bus usable within 1 ms after clear
// - serious fault asserts fuse-blow output
// - temperature from internal or thermistors
// - bus version 1.1, master and checking
// - bad temperature inhibits or suspends charge
// - charge current and voltage broadcast
// - clock low past timeout aborts transaction
module gst_supervisor #(
	parameter SENSE_W    = 16,
	parameter ACC_W      = 40,
	parameter TEMP_W     = 12,
	parameter CYCLE_CYC  = `GST_CYCLE_CYC,
	parameter BUSOFF_CYC = `GST_BUSOFF_CYC,
	parameter CAL_CYC    = `GST_CAL_CYC
) (
	// clock and reset
	input  wire                      clk,
	input  wire                      rst,
	// mode control
	input  wire                      sleep_req,
	input  wire                      shutdown_req,
	input  wire [31:0]               sleep_interval,
	input  wire                      master_enable,
	input  wire                      pec_enable,
	// pins from outside the clock domain
	input  wire                      system_present_input,
	input  wire                      bus_clock_line,
	input  wire                      bus_data_line,
	// sense path, already digitised
	input  wire signed [SENSE_W-1:0] sense_positive_input,
	input  wire signed [SENSE_W-1:0] sense_negative_input,
	input  wire signed [SENSE_W-1:0] sense_offset,
	// measurement results
	input  wire [15:0]               cell_raw,
	input  wire [15:0]               cell_gain,
	input  wire [15:0]               cell_offs,
	input  wire [TEMP_W-1:0]         temp_internal,
	input  wire [TEMP_W-1:0]         thermistor_input_a,
	input  wire [TEMP_W-1:0]         thermistor_input_b,
	input  wire [1:0]                temp_source,
	input  wire [TEMP_W-1:0]         temp_low_limit,
	input  wire [TEMP_W-1:0]         temp_high_limit,
	// protection and charge inputs
	input  wire                      fault_secondary,
	input  wire                      fault_primary,
	input  wire                      charge_request,
	input  wire [15:0]               cc_current,
	input  wire [15:0]               cv_voltage,
	// schedule and status outputs
	output reg  [1:0]                mode,
	output reg                       cycle_pulse,
	output reg                       system_present,
	output reg                       charging,
	output reg                       discharging,
	output reg  signed [ACC_W-1:0]   charge_acc,
	output reg  [15:0]               cell_voltage,
	output reg  [TEMP_W-1:0]         temperature,
	// bus supervision outputs
	output reg                       cal_start,
	output reg                       bus_off,
	output reg                       bus_ready,
	output reg                       bus_abort,
	output reg                       bus_master_en,
	output reg                       bus_pec_en,
	// protection and charge outputs
	output reg                       fuse_blow,
	output reg                       charge_allow,
	output reg                       broadcast_req,
	output reg  [15:0]               bcast_current,
	output reg  [15:0]               bcast_voltage
);
	// ============================================================
	// local constants
	localparam [2:0] ST_RUN   = 3'h1; // normal mode, active
	localparam [2:0] ST_SLEEP = 3'h2; // reduced power between cycles
	localparam [2:0] ST_OFF   = 3'h4; // shutdown
	localparam [31:0] RECOVER_CYC = `GST_RECOVER_CYC;
	localparam [31:0] TIMEOUT_CYC = `GST_TIMEOUT_CYC;
	localparam [31:0] ONE         = 32'h00000001;

	reg  [2:0]  state;        // one-hot supervisor state
	reg  [31:0] cyc_timer;    // cycle interval counter
	reg  [31:0] low_timer;    // both lines low duration
	reg  [31:0] clk_low_tmr;  // bus clock low duration
	reg  [31:0] rec_timer;    // bus-off recovery delay
	reg         recovering;   // counting toward bus ready
	reg         cal_done;     // one calibration per low stretch
	reg         fuse_latch;   // fuse never releases until reset
	wire        system_present_input_s;       // synchronised present pin
	wire        scl_s;        // synchronised bus clock
	wire        sda_s;        // synchronised bus data
	wire [31:0] interval;     // active cycle length
	wire        cycle_due;    // interval reached
	wire        wake;         // sleep wake condition
	wire signed [SENSE_W:0] vsr; // signed sense difference
	reg  [TEMP_W-1:0] next_temp; // selected temperature

	// ============================================================
	// helpers
	// saturating increment so a long-held level never wraps the timer
	function [31:0] sat_inc;
		input [31:0] v;
		begin
			sat_inc = (v == 32'hFFFFFFFF) ? v : v + ONE;
		end
	endfunction

	// ============================================================
	// pin synchronisers
	gst_sync #(.RESET_VAL(1'b1)) u_system_present_input (
		.clk  (clk),
		.rst  (rst),
		.din  (system_present_input),
		.dout (system_present_input_s)
	);
	gst_sync #(.RESET_VAL(1'b1)) u_scl (
		.clk  (clk),
		.rst  (rst),
		.din  (bus_clock_line),
		.dout (scl_s)
	);
	gst_sync #(.RESET_VAL(1'b1)) u_sda (
		.clk  (clk),
		.rst  (rst),
		.din  (bus_data_line),
		.dout (sda_s)
	);

	// ============================================================
	// combinational terms
	// sleep uses the programmed interval, zero falls back to one second
	assign interval  = (mode == `GST_MODE_SLEEP && sleep_interval != 32'h00000000) ?
		sleep_interval : CYCLE_CYC;
	assign cycle_due = (cyc_timer >= interval - ONE);
	assign vsr       = sense_positive_input - sense_negative_input;
	assign wake      = (vsr != {(SENSE_W+1){1'b0}}) || fault_primary || fault_secondary;

	// temperature source selection
	always @* begin
		next_temp = temp_internal;
		case (temp_source)
			`GST_TSRC_EXT_A: begin
				next_temp = thermistor_input_a;
			end
			`GST_TSRC_EXT_B: begin
				next_temp = thermistor_input_b;
			end
			`GST_TSRC_EXT_MAX: begin
				// both thermistors: report the hotter one
				next_temp = (thermistor_input_a > thermistor_input_b) ?
					thermistor_input_a : thermistor_input_b;
			end
			default: begin
				next_temp = temp_internal;
			end
		endcase
	end

	// ============================================================
	// mode state machine and cycle scheduler
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state       <= ST_RUN;
			mode        <= `GST_MODE_NORMAL;
			cyc_timer   <= 32'h00000000;
			cycle_pulse <= 1'b0;
		end else begin
			cycle_pulse <= 1'b0;
			case (state)
				ST_RUN: begin
					if (shutdown_req) begin
						state <= ST_OFF;
						mode  <= `GST_MODE_SHUTDOWN;
					end else if (cycle_due) begin
						cyc_timer   <= 32'h00000000;
						cycle_pulse <= 1'b1;
						if (sleep_req && !wake) begin
							state <= ST_SLEEP;
							mode  <= `GST_MODE_SLEEP;
						end
					end else begin
						cyc_timer <= sat_inc(cyc_timer); // count toward the next cycle
					end
				end
				ST_SLEEP: begin
					if (shutdown_req) begin
						state <= ST_OFF;
						mode  <= `GST_MODE_SHUTDOWN;
					end else if (wake || !sleep_req) begin
						state     <= ST_RUN;
						mode      <= `GST_MODE_NORMAL;
						cyc_timer <= 32'h00000000;
					end else if (cycle_due) begin
						cyc_timer   <= 32'h00000000;
						cycle_pulse <= 1'b1;
					end else begin
						cyc_timer <= sat_inc(cyc_timer);
					end
				end
				ST_OFF: begin
					// only reset leaves shutdown
					cyc_timer <= 32'h00000000;
				end
				default: begin
					state <= ST_RUN;
					mode  <= `GST_MODE_NORMAL;
				end
			endcase
		end
	end

	// ============================================================
	// per-cycle sampling: present pin, cell voltage, temperature
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			system_present <= 1'b0;
			cell_voltage   <= 16'h0000;
			temperature    <= {TEMP_W{1'b0}};
		end else if (state == ST_OFF) begin
			system_present <= 1'b0;
		end else if (cycle_pulse) begin
			system_present <= ~system_present_input_s;
			// scale then trim; upper product bits give unity gain at 0x8000
			cell_voltage   <= mul_scale(cell_raw, cell_gain) + cell_offs;
			temperature    <= next_temp;
		end
	end

	// fixed-point scale, gain 0x8000 is unity
	function [15:0] mul_scale;
		input [15:0] a;
		input [15:0] g;
		reg   [31:0] p;
		begin
			p = a * g;
			mul_scale = p[30:15];
		end
	endfunction

	// ============================================================
	// charge counting runs continuously outside shutdown
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			charge_acc  <= {ACC_W{1'b0}};
			charging    <= 1'b0;
			discharging <= 1'b0;
		end else if (state == ST_OFF) begin
			charging    <= 1'b0;
			discharging <= 1'b0;
		end else begin
			charging    <= (vsr > 0);
			discharging <= (vsr < 0);
			// one count per quantum, offset from calibration removed
			charge_acc  <= charge_acc + {{(ACC_W-SENSE_W-1){vsr[SENSE_W]}}, vsr}
				- {{(ACC_W-SENSE_W){sense_offset[SENSE_W-1]}}, sense_offset};
		end
	end

	// ============================================================
	// bus line supervision: off state, calibration, timeout
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			low_timer   <= 32'h00000000;
			clk_low_tmr <= 32'h00000000;
			rec_timer   <= 32'h00000000;
			recovering  <= 1'b0;
			bus_off     <= 1'b0;
			bus_ready   <= 1'b1;
			bus_abort   <= 1'b0;
			cal_start   <= 1'b0;
			cal_done    <= 1'b0;
		end else begin
			cal_start <= 1'b0;
			bus_abort <= 1'b0;
			// ready returns at the 1 ms limit; placed first so a
			// fresh bus-off entry in the same cycle wins over ready
			if (recovering && !bus_off) begin
				rec_timer <= sat_inc(rec_timer);
				if (rec_timer >= RECOVER_CYC - ONE) begin
					bus_ready  <= 1'b1;
					recovering <= 1'b0;
				end
			end
			if (scl_s || sda_s) begin
				low_timer <= 32'h00000000;
				cal_done  <= 1'b0;
				if (bus_off) begin
					bus_off    <= 1'b0;
					recovering <= 1'b1;
					rec_timer  <= 32'h00000000;
				end
			end else if (state != ST_OFF) begin
				low_timer <= sat_inc(low_timer);
				if (low_timer >= BUSOFF_CYC - ONE) begin
					bus_off    <= 1'b1;
					bus_ready  <= 1'b0;
					recovering <= 1'b0;
				end
				if (low_timer >= CAL_CYC - ONE && !cal_done) begin
					cal_start <= 1'b1;
					cal_done  <= 1'b1;
				end
			end
			// clock low timeout, counted separately, held clear in shutdown
			if (scl_s || state == ST_OFF) begin
				clk_low_tmr <= 32'h00000000;
			end else begin
				clk_low_tmr <= sat_inc(clk_low_tmr);
				if (clk_low_tmr == TIMEOUT_CYC - ONE) begin
					bus_abort <= 1'b1;
				end
			end
		end
	end

	// ============================================================
	// protection and charge control
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fuse_latch    <= 1'b0;
			fuse_blow     <= 1'b0;
			charge_allow  <= 1'b0;
			broadcast_req <= 1'b0;
			bcast_current <= 16'h0000;
			bcast_voltage <= 16'h0000;
			bus_master_en <= 1'b0;
			bus_pec_en    <= 1'b0;
		end else begin
			broadcast_req <= 1'b0;
			bus_master_en <= master_enable && (state != ST_OFF);
			bus_pec_en    <= pec_enable;
			// latched: a blown fuse is permanent by nature
			if (fault_secondary && state != ST_OFF) begin
				fuse_latch <= 1'b1;
			end
			fuse_blow <= fuse_latch | (fault_secondary && state != ST_OFF);
			// out-of-range temperature blocks start and suspends ongoing charge
			charge_allow <= charge_request && (state != ST_OFF) && !fuse_latch &&
				(temperature >= temp_low_limit) && (temperature <= temp_high_limit);
			if (cycle_pulse && master_enable && bus_ready && !bus_off) begin
				broadcast_req <= 1'b1;
				bcast_current <= charge_allow ? cc_current : 16'h0000;
				bcast_voltage <= cv_voltage;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/gst_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// host and charger side: drives the two bus lines and the present pin
module gst_host_model (
	// frame controls from the bench
	input  wire logic run,
	input  wire logic hold_low,
	input  wire logic clk_low,
	input  wire logic present,
	// pins toward the device
	output logic      bus_clock_line,
	output logic      bus_data_line,
	output logic      system_present_input
);
	logic lclk = 1'b1; // link clock, parked high outside frames
	logic ldat = 1'b1; // data toggles every bit so a stuck sample shows
	// odd start offset keeps the link clock out of phase with clk
	initial begin
		#7;
		forever #200 lclk = run ? ~lclk : 1'b1;
	end
	always @(negedge lclk) ldat <= ~ldat;
	// released lines sit at the pull-up level; driving high clears bus-off
	assign bus_clock_line = !(hold_low || clk_low) && lclk;
	assign bus_data_line = !hold_low && (run ? ldat : 1'b1);
	assign system_present_input = !present;
endmodule
`default_nettype wire

/* verif/gst_supervisor_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gst_map.vh"
// ============================================================
// timing checker on the supervisor's ports
module gst_supervisor_chk #(
	parameter SENSE_W    = 16,
	parameter CYCLE_CYC  = 50,
	parameter BUSOFF_CYC = 200,
	parameter CAL_CYC    = 500
) (
	// clock and reset
	input wire logic                      clk,
	input wire logic                      rst,
	// inputs seen
	input wire logic                      bus_clock_line,
	input wire logic                      bus_data_line,
	input wire logic                      fault_secondary,
	input wire logic signed [SENSE_W-1:0] sense_positive_input,
	input wire logic signed [SENSE_W-1:0] sense_negative_input,
	// outputs watched
	input wire logic [1:0]                mode,
	input wire logic                      cycle_pulse,
	input wire logic                      system_present,
	input wire logic                      charging,
	input wire logic                      discharging,
	input wire logic                      fuse_blow,
	input wire logic                      cal_start,
	input wire logic                      bus_off,
	input wire logic                      bus_ready,
	input wire logic                      bus_abort
);
	// run lengths; low_n and sclk_n count the raw pins and lead the filtered view by the synchroniser depth
	logic [31:0] gap, low_n, sclk_n, rec_n;
	logic        norm_run; // a whole normal-mode period is being timed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap <= '0;
			low_n <= '0;
			sclk_n <= '0;
			rec_n <= '0;
			norm_run <= 1'b0;
		end else begin
			gap <= cycle_pulse ? '0 : gap + 1;
			low_n <= (bus_clock_line || bus_data_line) ? '0 : low_n + 1;
			sclk_n <= bus_clock_line ? '0 : sclk_n + 1;
			rec_n <= bus_off ? '0 : rec_n + 1;
			norm_run <= (mode == `GST_MODE_NORMAL) && (norm_run || cycle_pulse);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ============================================================
	// assertions
	cycle_period_a: assert property (
		cycle_pulse && norm_run && mode == `GST_MODE_NORMAL |-> gap == CYCLE_CYC - 1)
		else $error("normal cycle period wrong");
	shutdown_quiet_a: assert property (
		mode == `GST_MODE_SHUTDOWN |-> !cycle_pulse && !cal_start && !bus_abort)
		else $error("activity in shutdown");
	present_hold_a: assert property (
		mode != `GST_MODE_SHUTDOWN && !$past(cycle_pulse) |-> $stable(system_present))
		else $error("present changed off cycle");
	sign_class_a: assert property (
		!$past(rst) && mode != `GST_MODE_SHUTDOWN && $past(mode) != `GST_MODE_SHUTDOWN
		|-> charging == $past(sense_positive_input > sense_negative_input)
		&& discharging == $past(sense_positive_input < sense_negative_input))
		else $error("charge sign wrong");
	fuse_set_a: assert property (
		fault_secondary && mode != `GST_MODE_SHUTDOWN |-> ##[1:4] fuse_blow)
		else $error("fuse not blown");
	fuse_hold_a: assert property (fuse_blow |=> fuse_blow)
		else $error("fuse released");
	sleep_wake_a: assert property (
		mode == `GST_MODE_SLEEP && fault_secondary |-> ##[1:4] mode != `GST_MODE_SLEEP)
		else $error("no wake on fault");
	busoff_entry_a: assert property (
		$rose(bus_off) |-> low_n >= BUSOFF_CYC && low_n <= BUSOFF_CYC + 8)
		else $error("bus off time wrong");
	cal_time_a: assert property (
		cal_start |-> low_n >= CAL_CYC && low_n <= CAL_CYC + 8)
		else $error("calibration time wrong");
	busoff_exit_a: assert property (
		(bus_off && (bus_clock_line || bus_data_line)) [*8] |=> !bus_off)
		else $error("bus off not cleared");
	ready_back_a: assert property (
		$rose(bus_ready) |-> rec_n >= 19990 && rec_n <= 20001 && !bus_off)
		else $error("bus recovery time wrong");
	abort_time_a: assert property (
		bus_abort |-> sclk_n >= `GST_TIMEOUT_CYC && sclk_n <= `GST_TIMEOUT_CYC + 8)
		else $error("abort time wrong");
	// main scenarios reached
	cover property (cal_start);
	cover property ($fell(bus_off));
	cover property (bus_abort);
endmodule
bind gst_supervisor gst_supervisor_chk #(
	.SENSE_W(SENSE_W), .CYCLE_CYC(CYCLE_CYC), .BUSOFF_CYC(BUSOFF_CYC), .CAL_CYC(CAL_CYC)
) gst_supervisor_chk_i (
	.clk, .rst, .bus_clock_line, .bus_data_line, .fault_secondary, .sense_positive_input,
	.sense_negative_input, .mode, .cycle_pulse, .system_present, .charging, .discharging,
	.fuse_blow, .cal_start, .bus_off, .bus_ready, .bus_abort
);
`default_nettype wire

/* verif/test_gauge_supervisor_timing.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gst_map.vh"
// ============================================================
// self-checking bench, short counts: cycle 50, bus-off 200, calibration 500
module test_gauge_supervisor_timing;
	// clock, reset, mode and bus options
	logic clk = 1'b0, rst = 1'b1, sleep_req = 1'b0, shutdown_req = 1'b0;
	logic master_enable = 1'b1, pec_enable = 1'b0;
	logic [31:0] sleep_interval = 32'h0000001E;
	// partner controls and pins
	logic run = 1'b0, hold_low = 1'b0, clk_low = 1'b0, present = 1'b0;
	logic system_present_input, bus_clock_line, bus_data_line;
	// sense, measurement, limit and charge inputs
	logic signed [15:0] sense_positive_input = '0, sense_negative_input = '0, sense_offset = '0;
	logic [15:0] cell_raw = 16'h4000, cell_gain = 16'h8000, cell_offs = 16'h0010;
	logic [11:0] temp_internal = 12'h00A, thermistor_input_a = 12'h032;
	logic [11:0] thermistor_input_b = 12'h01E;
	logic [11:0] temp_low_limit = 12'h014, temp_high_limit = 12'h032;
	logic [1:0] temp_source = 2'h0;
	logic fault_secondary = 1'b0, fault_primary = 1'b0, charge_request = 1'b1;
	logic [15:0] cc_current = 16'h0BB8, cv_voltage = 16'h3840;
	// design outputs
	logic [1:0] mode;
	logic cycle_pulse, system_present, charging, discharging, cal_start, bus_off, bus_ready;
	logic bus_abort, bus_master_en, bus_pec_en, fuse_blow, charge_allow, broadcast_req;
	logic signed [39:0] charge_acc, acc0;
	logic [15:0] cell_voltage, bcast_current, bcast_voltage;
	logic [11:0] temperature;
	int mismatches = 0, n_tests = 0, n;
	// one row per temperature source, covering each sense sign; the high limit is inclusive
	typedef struct {logic signed [15:0] p, q; logic [1:0] src;
		logic chg, dis, ok; logic [11:0] t;} gst_row_t;
	gst_row_t rows [4] = '{
		'{16'sh0010, 16'sh0000, 2'h0, 1'b1, 1'b0, 1'b0, 12'h00A},
		'{16'sh0000, 16'sh0010, 2'h1, 1'b0, 1'b1, 1'b1, 12'h032},
		'{16'sh0005, 16'sh0005, 2'h2, 1'b0, 1'b0, 1'b1, 12'h01E},
		'{16'sh8000, 16'sh7FFF, 2'h3, 1'b0, 1'b1, 1'b1, 12'h032}};
	always #25 clk = ~clk;
	gst_supervisor #(.CYCLE_CYC(50), .BUSOFF_CYC(200), .CAL_CYC(500)) gst_supervisor_i (
		.clk, .rst, .sleep_req, .shutdown_req, .sleep_interval, .master_enable, .pec_enable,
		.system_present_input, .bus_clock_line, .bus_data_line, .sense_positive_input,
		.sense_negative_input, .sense_offset, .cell_raw, .cell_gain, .cell_offs, .temp_internal,
		.thermistor_input_a, .thermistor_input_b, .temp_source, .temp_low_limit, .temp_high_limit,
		.fault_secondary, .fault_primary, .charge_request, .cc_current, .cv_voltage, .mode,
		.cycle_pulse, .system_present, .charging, .discharging, .charge_acc, .cell_voltage,
		.temperature, .cal_start, .bus_off, .bus_ready, .bus_abort, .bus_master_en, .bus_pec_en,
		.fuse_blow, .charge_allow, .broadcast_req, .bcast_current, .bcast_voltage);
	gst_host_model gst_host_model_i (.run, .hold_low, .clk_low, .present, .bus_clock_line,
		.bus_data_line, .system_present_input);
	// ============================================================
	// reporting
	task check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task print_verdict;
		if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// waits for the next measurement cycle, bounded
	task wait_pulse;
		repeat (200) if (cycle_pulse !== 1'b1) @(negedge clk);
		check(cycle_pulse === 1'b1, "no cycle");
	endtask
	// ============================================================
	// sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		pec_enable <= 1'b1;
		wait_pulse();
		@(negedge clk);
		check(broadcast_req === 1'b1, "broadcast");
		@(negedge clk);
		check(system_present === 1'b0, "present idle");
		check(cell_voltage === 16'h4010, "cell scaling");
		check(bus_master_en === 1'b1 && bus_pec_en === 1'b1, "bus options");
		foreach (rows[i]) begin
			@(posedge clk);
			present <= 1'b1;
			sense_positive_input <= rows[i].p;
			sense_negative_input <= rows[i].q;
			temp_source <= rows[i].src;
			// two cycles: the broadcast uses the previous cycle's decision
			repeat (2) begin
				wait_pulse();
				repeat (2) @(negedge clk);
			end
			check(charging === rows[i].chg && discharging === rows[i].dis, "sign");
			check(temperature === rows[i].t, "temperature");
			check(charge_allow === rows[i].ok, "charge window");
			check(bcast_current === (rows[i].ok ? cc_current : 16'h0000), "bcast cur");
			check(bcast_voltage === cv_voltage, "bcast volt");
			check(system_present === 1'b1, "present");
		end
		@(posedge clk);
		sense_positive_input <= 16'sh0010;
		sense_negative_input <= 16'sh0000;
		repeat (2) @(negedge clk);
		acc0 = charge_acc;
		repeat (10) @(negedge clk);
		check(charge_acc - acc0 === 40'sd160, "accumulate");
		// zero current so sleep is not refused
		@(posedge clk);
		sense_positive_input <= 16'sh0000;
		sleep_req <= 1'b1;
		repeat (200) if (mode !== `GST_MODE_SLEEP) @(negedge clk);
		check(mode === `GST_MODE_SLEEP, "sleep entry");
		wait_pulse();
		n = 0;
		@(negedge clk);
		while (cycle_pulse !== 1'b1 && n < 100) begin
			n++;
			@(negedge clk);
		end
		check(n == 29, "sleep interval");
		@(posedge clk);
		fault_secondary <= 1'b1;
		repeat (10) if (mode !== `GST_MODE_NORMAL) @(negedge clk);
		check(mode === `GST_MODE_NORMAL, "wake");
		@(posedge clk);
		fault_secondary <= 1'b0;
		sleep_req <= 1'b0;
		repeat (20) @(negedge clk);
		check(fuse_blow === 1'b1, "fuse latch");
		// live link traffic must not look like a stuck bus
		@(posedge clk);
		run <= 1'b1;
		n = 0;
		repeat (400) @(negedge clk) if (bus_abort !== 1'b0 || bus_off !== 1'b0) n++;
		check(n == 0, "frame traffic");
		@(posedge clk);
		run <= 1'b0;
		hold_low <= 1'b1;
		repeat (150) @(posedge clk);
		hold_low <= 1'b0;
		repeat (10) @(posedge clk);
		hold_low <= 1'b1;
		repeat (150) @(posedge clk);
		@(negedge clk);
		check(bus_off === 1'b0, "timer restart");
		repeat (100) if (bus_off !== 1'b1) @(negedge clk);
		check(bus_off === 1'b1 && bus_ready === 1'b0, "bus off");
		repeat (400) if (cal_start !== 1'b1) @(negedge clk);
		check(cal_start === 1'b1, "calibration");
		@(posedge clk);
		hold_low <= 1'b0;
		repeat (10) if (bus_off !== 1'b0) @(negedge clk);
		check(bus_off === 1'b0 && bus_ready === 1'b0, "bus off clear");
		n = 0;
		while (bus_ready !== 1'b1 && n < 20100) begin
			n++;
			@(negedge clk);
		end
		check(n >= 19990 && n <= 20001, "recovery");
		@(posedge clk);
		clk_low <= 1'b1;
		repeat (720) if (bus_abort !== 1'b1) @(negedge clk);
		check(bus_abort === 1'b1, "timeout abort");
		@(posedge clk);
		clk_low <= 1'b0;
		shutdown_req <= 1'b1;
		repeat (5) @(negedge clk);
		n = 0;
		repeat (100) @(negedge clk) if (cycle_pulse !== 1'b0) n++;
		check(mode === `GST_MODE_SHUTDOWN && n == 0 && bus_master_en === 1'b0, "shutdown");
		@(posedge clk);
		rst <= 1'b1;
		shutdown_req <= 1'b0;
		@(negedge clk);
		check(mode === `GST_MODE_NORMAL && bus_ready === 1'b1 && fuse_blow === 1'b0, "reset");
		@(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		print_verdict();
	end
	// hang guard, well past the expected run of about 23000 cycles
	initial begin
		#(60000 * 50);
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire
